// file: hdl/gpxr_pkg.sv
package gpxr_pkg;
	// Port geometry
	localparam int PINS = 8;
	localparam int SLAVE_ADDR_W = 7;
	localparam int ADDR_RW_BIT = 0;
	localparam int STAGE_OD_BIT = 0;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [1:0] WARMUP_CYCLES = 2'h3;
	// Command pointer codes
	localparam logic [7:0] PTR_IN = 8'h00;
	localparam logic [7:0] PTR_OUT = 8'h01;
	localparam logic [7:0] PTR_INV = 8'h02;
	localparam logic [7:0] PTR_DIR = 8'h03;
	localparam logic [7:0] PTR_DRV_LO = 8'h40;
	localparam logic [7:0] PTR_DRV_HI = 8'h41;
	localparam logic [7:0] PTR_CAP = 8'h42;
	localparam logic [7:0] PTR_BIAS_EN = 8'h43;
	localparam logic [7:0] PTR_BIAS_SEL = 8'h44;
	localparam logic [7:0] PTR_BLOCK = 8'h45;
	localparam logic [7:0] PTR_SRC = 8'h46;
	localparam logic [7:0] PTR_STAGE = 8'h4f;
	// Reset values
	localparam logic [7:0] RST_PTR = 8'h00;
	localparam logic [7:0] RST_OUT = 8'hff;
	localparam logic [7:0] RST_INV = 8'h00;
	localparam logic [7:0] RST_DIR = 8'hff;
	localparam logic [7:0] RST_DRV = 8'hff;
	localparam logic [7:0] RST_CAP = 8'h00;
	localparam logic [7:0] RST_BIAS_EN = 8'hff;
	localparam logic [7:0] RST_BIAS_SEL = 8'hff;
	localparam logic [7:0] RST_BLOCK = 8'hff;
	localparam logic [7:0] RST_STAGE = 8'h00;
	// Serial link states and byte roles
	typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK} gpxr_link_e;
	typedef enum logic [1:0] {K_ADDR, K_CMD, K_DATA} gpxr_byte_e;
endpackage

// file: hdl/gpxr_pin_if.sv
`timescale 1ns/1ps
interface gpxr_pin_if;
	import gpxr_pkg::*;
	logic [PINS-1:0] live;
	logic [PINS-1:0] dir;
	logic [PINS-1:0] capture_en;
	logic [PINS-1:0] block;
	logic [PINS-1:0] value;
	logic [PINS-1:0] source;
	logic rd_clear;
	modport watch(input live, dir, capture_en, block, rd_clear, output value, source);
	modport ctrl(output live, dir, capture_en, block, rd_clear, input value, source);
endinterface

// file: hdl/gpxr_sync.sv
`timescale 1ns/1ps
module gpxr_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Asynchronous in, synchronous out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	if (WIDTH < 1) begin : g_bad_width
		$error("gpxr_sync needs WIDTH of at least 1");
	end

	// Two stages; only the second stage is seen by logic
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// file: hdl/gpxr_pin_watch.sv
`timescale 1ns/1ps
module gpxr_pin_watch
	import gpxr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin state and configuration
	gpxr_pin_if.watch pins
);
	logic [PINS-1:0] snap;
	logic [PINS-1:0] cap_flag;
	logic [PINS-1:0] cap_val;
	logic [PINS-1:0] changed;
	logic [PINS-1:0] cap_set;
	logic [PINS-1:0] cap_use;
	logic [1:0] warm;
	logic armed;

	// Difference against the level last handed to the master
	assign armed = (warm == WARMUP_CYCLES);
	assign changed = pins.live ^ snap;
	assign cap_set = {PINS{armed}} & pins.dir & pins.capture_en & changed
		& (~cap_flag | {PINS{pins.rd_clear}});
	assign cap_use = cap_flag & pins.capture_en;

	// Hold off until the synchronisers carry real pin levels
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			warm <= '0;
		end else if (!armed) begin
			warm <= warm + 2'h1;
		end
	end

	// Reference level follows the pins until armed, then only on a port read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			snap <= '0;
		end else if (!armed || pins.rd_clear) begin
			snap <= pins.live;
		end
	end

	// Captures survive a reverting pin; a new change beats the read clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cap_flag <= '0;
			cap_val <= '0;
		end else begin
			cap_flag <= (pins.rd_clear ? '0 : cap_flag) | cap_set;
			cap_val <= (cap_val & ~cap_set) | (pins.live & cap_set);
		end
	end

	// Latched pins holding a capture show it, others the live level
	assign pins.value = (cap_use & cap_val) | (~cap_use & pins.live);
	// A captured change stays pending even after unlatching; outputs never count
	assign pins.source = {PINS{armed}} & pins.dir & ~pins.block
		& (cap_flag | (~pins.capture_en & changed));
endmodule

// file: hdl/gpxr_top.sv
`timescale 1ns/1ps
module gpxr_top
	import gpxr_pkg::*;
#(
	parameter logic [3:0] ADDR_BASE = 4'h4
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Serial bus
	input wire logic SCL,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	// Address straps
	input wire logic [2:0] ADDR_STRAP,
	// Port pins
	input wire logic [PINS-1:0] PORT_PIN_I,
	output logic [PINS-1:0] PORT_PIN_O,
	output logic [PINS-1:0] PORT_PIN_OE,
	// Pad controls
	output logic [2*PINS-1:0] DRIVE_LEVEL,
	output logic [PINS-1:0] BIAS_ENABLE,
	output logic [PINS-1:0] BIAS_SELECT,
	// Open-drain interrupt
	output logic IRQ_N_O,
	output logic IRQ_N_OE
);
	// Synchronised inputs
	logic [1:0] bus_q;
	logic [2:0] strap_q;
	logic [PINS-1:0] pins_live;
	logic scl;
	logic sda;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	// Link engine state
	gpxr_link_e link;
	gpxr_byte_e kind;
	logic [3:0] cnt;
	logic [7:0] shreg;
	logic rw;
	logic acked;
	logic sda_oe;
	logic [7:0] pointer;
	logic wr_stb;
	logic rd_clear;

	// Register file
	logic [7:0] out_level;
	logic [7:0] invert;
	logic [7:0] direction;
	logic [7:0] drv_lo;
	logic [7:0] drv_hi;
	logic [7:0] cap_en;
	logic [7:0] bias_en;
	logic [7:0] bias_sel;
	logic [7:0] block;
	logic stage;
	logic [7:0] port_val;
	logic [7:0] rd_byte;
	logic irq_active;

	gpxr_pin_if pw();

	// Bus lines and pins all come from outside MCLK
	gpxr_sync #(
		.WIDTH(2)
	) u_bus_sync (
		.clk(MCLK),
		.rst(SYS_RST),
		.d({SCL, SDA_I}),
		.q(bus_q)
	);

	gpxr_sync #(
		.WIDTH(3)
	) u_strap_sync (
		.clk(MCLK),
		.rst(SYS_RST),
		.d(ADDR_STRAP),
		.q(strap_q)
	);

	gpxr_sync #(
		.WIDTH(PINS)
	) u_pin_sync (
		.clk(MCLK),
		.rst(SYS_RST),
		.d(PORT_PIN_I),
		.q(pins_live)
	);

	gpxr_pin_watch u_watch (
		.clk(MCLK),
		.rst(SYS_RST),
		.pins(pw.watch)
	);

	assign scl = bus_q[1];
	assign sda = bus_q[0];

	// Previous bus levels for edge and condition detection
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			scl_d <= 1'b0;
			sda_d <= 1'b0;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
		end
	end

	// Start and stop are data edges while the clock stays high
	assign scl_rise = scl & ~scl_d;
	assign scl_fall = ~scl & scl_d;
	assign bus_start = scl & scl_d & sda_d & ~sda;
	assign bus_stop = scl & scl_d & ~sda_d & sda;

	// Byte engine: receive shifts on clock rise; transmit shifts, drive and decide on clock fall
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			link <= S_IDLE;
			kind <= K_ADDR;
			cnt <= '0;
			shreg <= '0;
			rw <= 1'b0;
			acked <= 1'b0;
			sda_oe <= 1'b0;
			pointer <= RST_PTR;
			wr_stb <= 1'b0;
			rd_clear <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			rd_clear <= 1'b0;
			if (bus_start) begin
				// A repeated start restarts address reception at any point
				link <= S_RX;
				kind <= K_ADDR;
				cnt <= '0;
				sda_oe <= 1'b0;
			end else if (bus_stop) begin
				link <= S_IDLE;
				sda_oe <= 1'b0;
			end else begin
				unique case (link)
					S_IDLE: begin
						sda_oe <= 1'b0;
					end
					S_RX: begin
						if (scl_rise) begin
							shreg <= {shreg[6:0], sda};
							cnt <= cnt + 4'h1;
						end else if (scl_fall && cnt == BYTE_BITS) begin
							unique case (kind)
								K_ADDR: begin
									if (shreg[7:1] == {ADDR_BASE, strap_q}) begin
										rw <= shreg[ADDR_RW_BIT];
										sda_oe <= 1'b1;
										link <= S_RX_ACK;
									end else begin
										link <= S_IDLE;
									end
								end
								K_CMD: begin
									pointer <= shreg;
									sda_oe <= 1'b1;
									link <= S_RX_ACK;
								end
								K_DATA: begin
									wr_stb <= 1'b1;
									sda_oe <= 1'b1;
									link <= S_RX_ACK;
								end
							endcase
						end
					end
					S_RX_ACK: begin
						if (scl_fall) begin
							cnt <= '0;
							if (kind == K_ADDR && rw) begin
								// Read starts at the stored pointer
								shreg <= rd_byte;
								sda_oe <= ~rd_byte[7];
								link <= S_TX;
							end else begin
								sda_oe <= 1'b0;
								kind <= (kind == K_ADDR) ? K_CMD : K_DATA;
								link <= S_RX;
							end
						end
					end
					S_TX: begin
						if (scl_rise) begin
							cnt <= cnt + 4'h1;
						end else if (scl_fall) begin
							if (cnt == BYTE_BITS) begin
								sda_oe <= 1'b0;
								link <= S_TX_ACK;
							end else begin
								shreg <= {shreg[6:0], 1'b0};
								sda_oe <= ~shreg[6];
							end
						end
					end
					S_TX_ACK: begin
						if (scl_rise) begin
							acked <= ~sda;
							// Clear lands on the ack or nack clock rise
							rd_clear <= (pointer == PTR_IN);
						end else if (scl_fall) begin
							if (acked) begin
								cnt <= '0;
								shreg <= rd_byte;
								sda_oe <= ~rd_byte[7];
								link <= S_TX;
							end else begin
								link <= S_IDLE;
							end
						end
					end
					default: begin
						link <= S_IDLE;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// Register writes; read-only and unmapped codes are acked but dropped
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			out_level <= RST_OUT;
			invert <= RST_INV;
			direction <= RST_DIR;
			drv_lo <= RST_DRV;
			drv_hi <= RST_DRV;
			cap_en <= RST_CAP;
			bias_en <= RST_BIAS_EN;
			bias_sel <= RST_BIAS_SEL;
			block <= RST_BLOCK;
			stage <= RST_STAGE[STAGE_OD_BIT];
		end else if (wr_stb) begin
			case (pointer)
				PTR_OUT: out_level <= shreg;
				PTR_INV: invert <= shreg;
				PTR_DIR: direction <= shreg;
				PTR_DRV_LO: drv_lo <= shreg;
				PTR_DRV_HI: drv_hi <= shreg;
				PTR_CAP: cap_en <= shreg;
				PTR_BIAS_EN: bias_en <= shreg;
				PTR_BIAS_SEL: bias_sel <= shreg;
				PTR_BLOCK: block <= shreg;
				PTR_STAGE: stage <= shreg[STAGE_OD_BIT];
				default: begin
					// Input port and status ignore writes
				end
			endcase
		end
	end

	// Configuration seen by the change watcher
	assign pw.live = pins_live;
	assign pw.dir = direction;
	assign pw.capture_en = cap_en;
	assign pw.block = block;
	assign pw.rd_clear = rd_clear;

	// Inversion applies to input pins only
	assign port_val = pw.value ^ (invert & direction);

	// Read selection; sampled only when a byte is loaded for sending
	always_comb begin
		case (pointer)
			PTR_IN: rd_byte = port_val;
			PTR_OUT: rd_byte = out_level;
			PTR_INV: rd_byte = invert;
			PTR_DIR: rd_byte = direction;
			PTR_DRV_LO: rd_byte = drv_lo;
			PTR_DRV_HI: rd_byte = drv_hi;
			PTR_CAP: rd_byte = cap_en;
			PTR_BIAS_EN: rd_byte = bias_en;
			PTR_BIAS_SEL: rd_byte = bias_sel;
			PTR_BLOCK: rd_byte = block;
			PTR_SRC: rd_byte = pw.source;
			PTR_STAGE: rd_byte = {7'h00, stage};
			default: rd_byte = 8'h00;
		endcase
	end

	// Interrupt line registered so it never glitches on pin noise
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_active <= 1'b0;
		end else begin
			irq_active <= |pw.source;
		end
	end

	// Open-drain stages only ever pull low
	assign SDA_O = 1'b0;
	assign SDA_OE = sda_oe;
	assign IRQ_N_O = 1'b0;
	assign IRQ_N_OE = irq_active;

	// Output pins; open-drain mode releases the pin for a one
	assign PORT_PIN_O = out_level;
	assign PORT_PIN_OE = ~direction & (~{PINS{stage}} | ~out_level);

	// Pad strength and bias; bias is cut off in open-drain mode
	assign DRIVE_LEVEL = {drv_hi, drv_lo};
	assign BIAS_ENABLE = bias_en & ~{PINS{stage}};
	assign BIAS_SELECT = bias_sel;
endmodule

// file: verification/gpxr_top_monitor.sv
`timescale 1ns/1ps
module gpxr_top_monitor
	import gpxr_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Bus and pins
	input wire logic SCL,
	input wire logic SDA_OE,
	input wire logic [PINS-1:0] PORT_PIN_I,
	input wire logic [PINS-1:0] PORT_PIN_O,
	input wire logic [PINS-1:0] PORT_PIN_OE,
	// Pad controls and interrupt
	input wire logic [2*PINS-1:0] DRIVE_LEVEL,
	input wire logic [PINS-1:0] BIAS_ENABLE,
	input wire logic [PINS-1:0] BIAS_SELECT,
	input wire logic IRQ_N_OE
);
	logic [3:0] quiet;
	logic [PINS-1:0] pin_q;
	logic scl_q;
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (SYS_RST);
	// Cycles since a pin or the bus clock moved; an interrupt edge needs such a cause
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			quiet <= 4'h0;
			pin_q <= '0;
			scl_q <= 1'b1;
		end else begin
			pin_q <= PORT_PIN_I;
			scl_q <= SCL;
			if (PORT_PIN_I != pin_q || SCL != scl_q) begin
				quiet <= 4'h0;
			end else if (quiet != 4'hf) begin
				quiet <= quiet + 4'h1;
			end
		end
	end
	// Data line moves, then holds for the rest of the bit
	sequence s_oe_move;
		$changed(SDA_OE);
	endsequence
	sequence s_oe_hold;
		$stable(SDA_OE) [*6];
	endsequence
	a_reset_vals:
	assert property ($fell(SYS_RST) |-> PORT_PIN_OE == 8'h00 && PORT_PIN_O == 8'hff
		&& DRIVE_LEVEL == 16'hffff && {BIAS_ENABLE, BIAS_SELECT} == 16'hffff && !SDA_OE)
		else $error("pad outputs off reset values");
	a_irq_quiet_start:
	assert property ($fell(SYS_RST) |-> !IRQ_N_OE [*3])
		else $error("interrupt right after reset");
	a_sda_scl_low:
	assert property (s_oe_move |-> !SCL)
		else $error("data line moved with clock high");
	a_sda_bit_held:
	assert property (s_oe_move |=> s_oe_hold)
		else $error("data line not held for a bit");
	a_irq_output_pins:
	assert property ($rose(IRQ_N_OE) |-> PORT_PIN_OE != 8'hff)
		else $error("interrupt with all pins outputs");
	a_irq_rise_cause:
	assert property ($rose(IRQ_N_OE) |-> quiet < 4'h8)
		else $error("interrupt rose without cause");
	a_irq_fall_cause:
	assert property ($fell(IRQ_N_OE) |-> quiet < 4'h8)
		else $error("interrupt fell without cause");
	// Pads move a synchroniser lag after the bus clock fell, so look back three samples
	a_pads_scl_low:
	assert property ($changed({PORT_PIN_O, DRIVE_LEVEL, BIAS_SELECT}) |-> !$past(SCL, 3))
		else $error("pad control moved outside a bus clock low phase");
endmodule
bind gpxr_top gpxr_top_monitor u_mon (.MCLK(MCLK), .SYS_RST(SYS_RST), .SCL(SCL),
	.SDA_OE(SDA_OE), .PORT_PIN_I(PORT_PIN_I), .PORT_PIN_O(PORT_PIN_O),
	.PORT_PIN_OE(PORT_PIN_OE), .DRIVE_LEVEL(DRIVE_LEVEL), .BIAS_ENABLE(BIAS_ENABLE),
	.BIAS_SELECT(BIAS_SELECT), .IRQ_N_OE(IRQ_N_OE));

// file: verification/gpxr_bus_model.sv
`timescale 1ns/1ps
module gpxr_bus_model (
	// Clock
	input wire logic clk,
	// Bus lines
	output logic scl,
	output logic sda_dn,
	input wire logic sda,
	// Target address
	input wire logic [6:0] adr
);
	logic s;
	initial begin
		scl = 1'b1;
		sda_dn = 1'b0;
	end
	// Quarter bit of 40 ns; lines move just after a clock edge
	task automatic q();
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Data set mid-low, sampled mid-high, so the slave's lag is harmless
	task automatic bit_x(input logic b, output logic r);
		q();
		sda_dn = !b;
		q();
		scl = 1'b1;
		q();
		r = sda;
		q();
		scl = 1'b0;
	endtask
	// Start, also used as repeated start
	task automatic start();
		q();
		sda_dn = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_dn = 1'b1;
		q();
		scl = 1'b0;
	endtask
	task automatic stop();
		q();
		sda_dn = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_dn = 1'b0;
		q();
	endtask
	// Byte out MSB first, then the slave's acknowledge
	task automatic tx(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(d[i], s);
		bit_x(1'b1, s);
		ack = !s;
	endtask
	// Byte in, closed by an acknowledge unless it is the last
	task automatic rx(output logic [7:0] d, input logic last);
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(last, s);
	endtask
	// Pointer first, then one data byte
	task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		tx({adr, 1'b0}, a0);
		tx(p, a1);
		tx(d, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask
	// Pointer write, repeated start, read byte
	task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		tx({adr, 1'b0}, a0);
		tx(p, a1);
		start();
		tx({adr, 1'b1}, a2);
		rx(d, 1'b1);
		stop();
		ok = a0 & a1 & a2;
	endtask
	// Two bytes from one pointer; the master acks the first
	task automatic rd2(input logic [7:0] p, output logic [15:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		tx({adr, 1'b0}, a0);
		tx(p, a1);
		start();
		tx({adr, 1'b1}, a2);
		rx(d[15:8], 1'b0);
		rx(d[7:0], 1'b1);
		stop();
		ok = a0 & a1 & a2;
	endtask
endmodule

// file: verification/gpxr_top_tb.sv
`timescale 1ns/1ps
module gpxr_top_tb;
	import gpxr_pkg::*;
	logic mclk, sys_rst, scl, sda_dn, sda_oe, irq_oe, ok, sda_o, irq_o;
	logic [2:0] strap;
	logic [6:0] m_adr;
	logic [7:0] ext, pin_o, pin_oe, bias_en, bias_sel, v;
	logic [15:0] drv, v2;
	int error_cnt, n_checks;
	// Pointer and value after reset; 10h is unmapped
	logic [15:0] rtab [13] = '{16'h00a5, 16'h01ff, 16'h0200, 16'h03ff, 16'h40ff, 16'h41ff,
		16'h4200, 16'h43ff, 16'h44ff, 16'h45ff, 16'h4600, 16'h4f00, 16'h1000};
	// Pointer, value written, value read back
	logic [23:0] wtab [11] = '{24'h015a5a, 24'h02ffff, 24'h401b1b, 24'h41e4e4, 24'h43c3c3,
		24'h443c3c, 24'h4ffe00, 24'h00ff5a, 24'h46ff00, 24'h107700, 24'h03f0f0};
	// Pull-up wins when nobody pulls; driven pins show the design's level
	wire sda = !(sda_oe || sda_dn);
	wire [7:0] pins = (pin_oe & pin_o) | (~pin_oe & ext);
	gpxr_top dut (.MCLK(mclk), .SYS_RST(sys_rst), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
		.SDA_OE(sda_oe), .ADDR_STRAP(strap), .PORT_PIN_I(pins), .PORT_PIN_O(pin_o),
		.PORT_PIN_OE(pin_oe), .DRIVE_LEVEL(drv), .BIAS_ENABLE(bias_en),
		.BIAS_SELECT(bias_sel), .IRQ_N_O(irq_o), .IRQ_N_OE(irq_oe));
	gpxr_bus_model m (.clk(mclk), .scl(scl), .sda_dn(sda_dn), .sda(sda), .adr(m_adr));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic w(input logic [7:0] p, input logic [7:0] d);
		m.wr(p, d, ok);
		chk("write ack", ok, 16'h1);
	endtask
	task automatic r(input logic [7:0] p, input logic [7:0] e);
		m.rd(p, v, ok);
		chk("read ack", ok, 16'h1);
		chk($sformatf("reg %h", p), v, e);
	endtask
	// Fixed wait covers the three-cycle pin to interrupt lag
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (50000) @(posedge mclk);
		error_cnt++;
		end_of_test();
	end
	initial begin
		sys_rst = 1'b1;
		strap = 3'h5;
		m_adr = 7'h25;
		ext = 8'ha5;
		tick(10);
		sys_rst = 1'b0;
		tick(10);
		chk("pads", {pin_oe, pin_o}, 16'h00ff);
		chk("drive", drv, 16'hffff);
		chk("bias", {bias_en, bias_sel}, 16'hffff);
		chk("open drain lows", {sda_o, irq_o}, 16'h0);
		foreach (rtab[i]) r(rtab[i][15:8], rtab[i][7:0]);
		$display("reset test done");
		// Inversion set on every pin only shows on the inputs
		foreach (wtab[i]) w(wtab[i][23:16], wtab[i][15:8]);
		foreach (wtab[i]) r(wtab[i][23:16], wtab[i][7:0]);
		// Acked first byte keeps sending from the same pointer
		m.rd2(8'h01, v2, ok);
		chk("burst ack", ok, 16'h1);
		chk("burst", v2, 16'h5a5a);
		chk("pads", {pin_oe, pin_o}, 16'h0f5a);
		chk("drive", drv, 16'he41b);
		chk("bias", {bias_en, bias_sel}, 16'hc33c);
		w(8'h4f, 8'h01);
		chk("open drain", {pin_oe, bias_en}, 16'h0500);
		w(8'h4f, 8'h00);
		$display("register test done");
		// Foreign address is ignored until the straps match it
		m_adr = 7'h24;
		m.wr(8'h01, 8'h00, ok);
		chk("foreign ack", ok, 16'h0);
		chk("out kept", pin_o, 16'h5a);
		strap = 3'h4;
		tick(5);
		w(8'h01, 8'h50);
		chk("out", pin_o, 16'h50);
		$display("address test done");
		// Unlatched inputs
		w(8'h02, 8'h00);
		w(8'h45, 8'h00);
		r(8'h00, 8'ha0);
		chk("irq", irq_oe, 16'h0);
		ext = ext ^ 8'h10;
		tick(5);
		chk("irq", irq_oe, 16'h1);
		r(8'h46, 8'h10);
		ext = ext ^ 8'h10;
		tick(5);
		chk("irq", irq_oe, 16'h0);
		ext = ext ^ 8'h10;
		tick(5);
		r(8'h00, 8'hb0);
		chk("irq", irq_oe, 16'h0);
		w(8'h01, 8'h5f);
		chk("irq", irq_oe, 16'h0);
		ext = ext ^ 8'h20;
		tick(5);
		w(8'h45, 8'h20);
		chk("irq", irq_oe, 16'h0);
		r(8'h46, 8'h00);
		w(8'h45, 8'h00);
		chk("irq", irq_oe, 16'h1);
		r(8'h00, 8'h9f);
		$display("interrupt test done");
		// Latched pin 4 and unlatched pin 5 move together, then both revert
		w(8'h42, 8'h10);
		ext = ext ^ 8'h30;
		tick(5);
		ext = ext ^ 8'h30;
		tick(5);
		chk("irq", irq_oe, 16'h1);
		r(8'h00, 8'h8f);
		chk("irq", irq_oe, 16'h0);
		r(8'h00, 8'h9f);
		ext = ext ^ 8'h10;
		tick(5);
		ext = ext ^ 8'h10;
		tick(5);
		w(8'h42, 8'h00);
		chk("irq", irq_oe, 16'h1);
		r(8'h00, 8'h9f);
		chk("irq", irq_oe, 16'h0);
		$display("latch test done");
		// Reset in mid-run restores the defaults
		sys_rst = 1'b1;
		tick(3);
		sys_rst = 1'b0;
		tick(10);
		chk("pads", {pin_oe, pin_o}, 16'h00ff);
		r(8'h01, 8'hff);
		r(8'h00, 8'h95);
		$display("second reset test done");
		end_of_test();
	end
endmodule
